// ### rtl/seven_source_interrupt_prioritizer.sv
// seven-source interrupt prioritizer with apb registers and vector handshake
//
// Summary of operation
// - seven vectors: two external, three timers, serial, array
// - per-source enable bit gates only its source
// - global enable low blocks every new request; one already standing is still held
// - each source picks one of four levels
// - level equals high bit then low bit
// - counter array vectors to 0033H, others standard
// - same level ties resolved in fixed order
// - high level register at B7h, bits 6..0
// - high register resets zero, whole-word access
// - serial and timer two each ORed flags
`timescale 1ns/1ps

module seven_source_interrupt_prioritizer
  import irq_prio_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral event lines, active high
  input irq_src_t srcIn,
  // core side
  output vec_req_t vecReq,
  input wire logic vecAck,
  input wire logic retiPulse,
  output logic irqOut
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [6:0] levelHi_q;
  logic [6:0] levelLo_q;
  logic [6:0] enable_q;
  logic globalEn_q;
  logic [3:0] active_q; // one bit per level currently in service
  logic [1:0] evStat_q;
  logic [1:0] evEn_q;
  logic [31:0] prdata_q;
  vec_req_t vecReq_q;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire apbWr = psel && penable && pwrite;
  wire apbRd = psel && penable && !pwrite;
  wire hitHi = (paddr == ADDR_LEVEL_HI);
  wire hitLo = (paddr == ADDR_LEVEL_LO);
  wire hitEn = (paddr == ADDR_ENABLE);
  wire hitSt = (paddr == ADDR_STATUS);
  wire hitCt = (paddr == ADDR_CTRL);
  wire hitIs = (paddr == ADDR_IRQ_STAT);
  wire hitIc = (paddr == ADDR_IRQ_CLR);
  wire hitIe = (paddr == ADDR_IRQ_EN);
  wire mapped = hitHi | hitLo | hitEn | hitSt | hitCt | hitIs | hitIc | hitIe;
  // software return request, from the control register return bit only
  wire swReti = apbWr && hitCt && pwdata[CTRL_RETI_BIT];

  assign pready = 1'b1; // zero wait state
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  // ---------------------------------------------------------------
  // request collection and level lookup
  // ---------------------------------------------------------------
  logic [6:0] rawReq;
  assign rawReq[SRC_EXT0] = srcIn.externalIrqZero;
  assign rawReq[SRC_TMR0] = srcIn.timerZeroOverflowFlag;
  assign rawReq[SRC_EXT1] = srcIn.externalIrqOne;
  assign rawReq[SRC_TMR1] = srcIn.timerOneOverflowFlag;
  assign rawReq[SRC_SER] = srcIn.serialReceiveFlag | srcIn.serialTransmitFlag;
  assign rawReq[SRC_TMR2] = srcIn.timerTwoOverflowFlag | srcIn.timerTwoExternalFlag;
  assign rawReq[SRC_CNT] = srcIn.counterArray;

  wire [6:0] pend = rawReq & enable_q & {7{globalEn_q}};

  function automatic logic [15:0] vecOf(input logic [2:0] s);
    case (s)
      3'd0: vecOf = VEC_EXT0;
      3'd1: vecOf = VEC_TMR0;
      3'd2: vecOf = VEC_EXT1;
      3'd3: vecOf = VEC_TMR1;
      3'd4: vecOf = VEC_SER;
      3'd5: vecOf = VEC_TMR2;
      default: vecOf = VEC_CNT;
    endcase
  endfunction

  // highest active service level, -1 encoded as noneActive
  wire noneActive = (active_q == 4'h0);
  logic [1:0] curLvl;
  always_comb begin
    curLvl = 2'd0;
    for (int l = 0; l < 4; l++) begin
      if (active_q[l]) begin
        curLvl = l[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // winner selection: highest level, then lowest index
  // ---------------------------------------------------------------
  logic found;
  logic [2:0] winSrc;
  logic [1:0] winLvl;
  always_comb begin
    found = 1'b0;
    winSrc = 3'd0;
    winLvl = 2'd0;
    // level = {high bit, low bit}
    // descending scan so lowest index keeps ties
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i] && (!found || {levelHi_q[i], levelLo_q[i]} >= winLvl)) begin
        found = 1'b1;
        winSrc = i[2:0];
        winLvl = {levelHi_q[i], levelLo_q[i]};
      end
    end
  end

  // only a strictly higher level may interrupt a running handler
  wire canTake = found && (noneActive || winLvl > curLvl);

  // ---------------------------------------------------------------
  // vector request register: held until the core acknowledges
  // ---------------------------------------------------------------
  // the word freezes while it stands, so a source that drops before ack is still served
  wire taken = vecReq_q.valid && vecAck;
  wire retEv = (retiPulse || swReti) && !noneActive;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      vecReq_q <= '0;
    end else if (!vecReq_q.valid || vecAck) begin
      vecReq_q.valid <= canTake && !taken;
      vecReq_q.source <= winSrc;
      vecReq_q.level <= winLvl;
      vecReq_q.addr <= vecOf(winSrc);
    end
  end
  assign vecReq = vecReq_q;

  // in-service levels: set on acknowledge, highest cleared on return
  logic [3:0] clrMask;
  always_comb begin
    clrMask = 4'h0;
    clrMask[curLvl] = retEv;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      active_q <= 4'h0;
    end else begin
      active_q <= (active_q & ~clrMask) | (taken ? (4'h1 << vecReq_q.level) : 4'h0);
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // high level bits 6..0 at the mapped word
  // whole-word write only, reset to zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      levelHi_q <= RST_LEVEL;
      levelLo_q <= RST_LEVEL;
      enable_q <= RST_ENABLE;
      globalEn_q <= RST_GLOBAL;
      evEn_q <= 2'b00;
    end else if (apbWr) begin
      if (hitHi) begin
        levelHi_q <= pwdata[6:0];
      end else if (hitLo) begin
        levelLo_q <= pwdata[6:0];
      end else if (hitEn) begin
        enable_q <= pwdata[6:0];
      end else if (hitCt) begin
        globalEn_q <= pwdata[CTRL_GLOBAL_BIT];
      end else if (hitIe) begin
        evEn_q <= pwdata[1:0];
      end
    end
  end

  // sticky events; a new event beats a simultaneous clear
  wire [1:0] evSet = {retEv, taken};
  wire [1:0] evClr = (apbWr && hitIc) ? pwdata[1:0] : 2'b00;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      evStat_q <= 2'b00;
    end else begin
      evStat_q <= (evStat_q & ~evClr) | evSet;
    end
  end
  assign irqOut = |(evStat_q & evEn_q);

  // read mux; bit 7 of the high word reads zero (software must not set it)
  logic [31:0] rdVal;
  always_comb begin
    rdVal = 32'h0000_0000;
    if (hitHi) begin
      rdVal[6:0] = levelHi_q;
    end else if (hitLo) begin
      rdVal[6:0] = levelLo_q;
    end else if (hitEn) begin
      rdVal[6:0] = enable_q;
    end else if (hitSt) begin
      rdVal[6:0] = pend;
      rdVal[11:8] = active_q;
    end else if (hitCt) begin
      rdVal[CTRL_GLOBAL_BIT] = globalEn_q;
    end else if (hitIs) begin
      rdVal[1:0] = evStat_q;
    end else if (hitIe) begin
      rdVal[1:0] = evEn_q;
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rdVal; // captured in setup so data is ready in access
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // gates only stop new requests; one already standing is held for the core
  a_global_gate_off: assert property (!globalEn_q && (!vecReq_q.valid || vecAck)
    |=> !vecReq_q.valid)
    else $error("request raised while global enable off");
  a_enable_gate: assert property (!vecReq_q.valid && !enable_q[winSrc]
    |=> !vecReq_q.valid)
    else $error("request from disabled source");
  a_array_vector: assert property (vecReq_q.valid && vecReq_q.source == 3'd6 |-> vecReq_q.addr == 16'h0033)
    else $error("counter array vector wrong");
  a_level_code: assert property (vecReq_q.valid
    && !$changed(levelHi_q) && !$changed(levelLo_q)
    |-> vecReq_q.level == {levelHi_q[vecReq_q.source], levelLo_q[vecReq_q.source]})
    else $error("level code mismatch");
  a_hi_write: assert property (apbWr && hitHi |=> levelHi_q == $past(pwdata[6:0]))
    else $error("high level write lost");
  a_serial_or: assert property (globalEn_q && enable_q[4] && srcIn.serialTransmitFlag
    |-> pend[4])
    else $error("transmit flag does not request serial");
  a_timer_two_or: assert property (globalEn_q && enable_q[SRC_TMR2]
    && srcIn.timerTwoExternalFlag |-> pend[SRC_TMR2])
    else $error("timer two external flag does not request");
  a_nest_block: assert property (vecReq_q.valid && !noneActive
    |-> vecReq_q.level > curLvl || $past(retEv) || $past(taken))
    else $error("same level preempted handler");
  a_tie_order: assert property (found && pend[0]
    && winLvl == {levelHi_q[0], levelLo_q[0]} |-> winSrc == 3'd0)
    else $error("tie order broken");
  a_four_levels: assert property (taken |=> active_q[$past(vecReq_q.level)])
    else $error("taken level not marked active");
  a_seven_src: assert property (vecReq_q.valid |-> vecReq_q.source <= 3'd6)
    else $error("source index out of range");
  a_reset_zero: assert property ($fell(sys_rst) |-> levelHi_q == 7'h00)
    else $error("high level not zero after reset");

  // apb side: the high word reads back its seven bits with zero above them
  a_hi_read: assert property (apbRd && hitHi |-> prdata_q == {25'h000_0000, levelHi_q})
    else $error("high level readback wrong");

  // vector handshake steps: a request stands unchanged until taken, then drops
  sequence s_req_open;
    vecReq_q.valid && !vecAck;
  endsequence
  sequence s_req_taken;
    vecReq_q.valid && vecAck;
  endsequence
  a_vec_hold: assert property (s_req_open |=> vecReq_q.valid && $stable(vecReq_q))
    else $error("vector request changed before acknowledge");
  a_ack_drop: assert property (s_req_taken |=> !vecReq_q.valid)
    else $error("vector request stood after acknowledge");

  // nesting and events: a return frees the level it ends and a taken event is kept
  a_retire_level: assert property (retEv |=> !active_q[$past(curLvl)])
    else $error("returned level still in service");
  a_event_set: assert property (taken |=> evStat_q[EV_TAKEN_BIT])
    else $error("taken event lost");

endmodule

// ### rtl/irq_prio_pkg.sv
// constants and types shared by the seven-source interrupt prioritizer
package irq_prio_pkg;

  localparam int NUM_SRC = 7;

  // apb byte addresses (printed offset 0xb7 is not a multiple of four: index*4)
  localparam logic [7:0] IDX_LEVEL_HI = 8'hb7;
  localparam logic [11:0] ADDR_LEVEL_HI = {2'h0, IDX_LEVEL_HI, 2'h0};
  localparam logic [11:0] ADDR_LEVEL_LO = 12'h0000;
  localparam logic [11:0] ADDR_ENABLE = 12'h0004;
  localparam logic [11:0] ADDR_STATUS = 12'h0008;
  localparam logic [11:0] ADDR_CTRL = 12'h000c;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h0010;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h0014;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h0018;

  // reset values
  localparam logic [6:0] RST_LEVEL = 7'h00;
  localparam logic [6:0] RST_ENABLE = 7'h00;
  localparam logic RST_GLOBAL = 1'b0;

  // control register field positions
  localparam int CTRL_GLOBAL_BIT = 0;
  localparam int CTRL_RETI_BIT = 1;

  // event status bit positions
  localparam int EV_TAKEN_BIT = 0;
  localparam int EV_RETURN_BIT = 1;

  // source order: index 0 wins ties, index 6 (counter array) loses
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_SER = 4;
  localparam int SRC_TMR2 = 5;
  localparam int SRC_CNT = 6;

  // vector addresses per source
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_TMR0 = 16'h000b;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TMR1 = 16'h001b;
  localparam logic [15:0] VEC_SER = 16'h0023;
  localparam logic [15:0] VEC_TMR2 = 16'h002b;
  localparam logic [15:0] VEC_CNT = 16'h0033;

  // raw event lines from the peripherals
  typedef struct packed {
    logic counterArray;
    logic timerTwoExternalFlag;
    logic timerTwoOverflowFlag;
    logic serialTransmitFlag;
    logic serialReceiveFlag;
    logic timerOneOverflowFlag;
    logic externalIrqOne;
    logic timerZeroOverflowFlag;
    logic externalIrqZero;
  } irq_src_t;

  // vector request toward the core
  typedef struct packed {
    logic valid;
    logic [2:0] source;
    logic [1:0] level;
    logic [15:0] addr;
  } vec_req_t;

endpackage

// ### dv/core_model.sv
// core-side model: takes vector requests and signals handler return
`timescale 1ns/1ps

module core_model
  import irq_prio_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input vec_req_t vecReq,
  input wire logic [3:0] ackDelay,
  output logic vecAck,
  output logic retiPulse
);
  logic [3:0] waitQ;

  // ack after ackDelay cycles; a slow core keeps the request standing
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      waitQ <= 4'h0;
      vecAck <= 1'b0;
    end else begin
      vecAck <= 1'b0;
      if (vecReq.valid && !vecAck && waitQ == ackDelay) begin
        vecAck <= 1'b1;
        waitQ <= 4'h0;
      end else if (vecReq.valid && !vecAck) begin
        waitQ <= waitQ + 4'h1;
      end
    end
  end

  // handler return
  // one-cycle pulse ends the highest active level
  task automatic give_return();
    @(posedge clk_sys);
    retiPulse <= 1'b1;
    @(posedge clk_sys);
    retiPulse <= 1'b0;
  endtask

  initial retiPulse = 1'b0;
endmodule

// ### dv/seven_source_interrupt_prioritizer_test.sv
// self-checking bench for the seven-source interrupt prioritizer
`timescale 1ns/1ps

module seven_source_interrupt_prioritizer_test
  import irq_prio_pkg::*;
();
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  irq_src_t srcIn = irq_src_t'(9'h000);
  vec_req_t vecReq;
  logic vecAck;
  logic retiPulse;
  logic irqOut;
  logic [3:0] ackDelay = 4'h0;
  int n_errors = 0;
  int n_checks = 0;

  always #5 clk_sys = ~clk_sys;

  seven_source_interrupt_prioritizer dut (.clk_sys, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .srcIn, .vecReq, .vecAck, .retiPulse,
    .irqOut);
  core_model core (.clk_sys, .sys_rst, .vecReq, .ackDelay, .vecAck, .retiPulse);

  // ----
  // tasks
  // ----
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp, string msg);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // a wait that runs out ends the run rather than hanging it
  task automatic guard(int n);
    if (n >= 20) begin
      n_errors++;
      $display("wrong value at %0t: timeout", $time);
      stop_test();
    end
  endtask

  // one apb transfer: setup, then access until pready is sampled high
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    guard(n);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] exp, string msg);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp, msg);
  endtask

  task automatic idle(int n);
    repeat (n) begin
      @(posedge clk_sys);
      chk({31'h0000_0000, vecReq.valid}, 32'h0000_0000, "idle");
    end
  endtask

  // flag bit to source: serial and timer two each merge two flags
  function automatic int src_of(int b);
    return (b < 4) ? b : (b + 4) / 2;
  endfunction

  function automatic logic [8:0] mask_of(int s);
    logic [8:0] m;
    m = 9'h000;
    for (int b = 0; b < 9; b++) begin
      m[b] = (src_of(b) == s);
    end
    return m;
  endfunction

  // wait for a vector, check it, drop its flags, then optionally retire it
  task automatic wait_vec(int s, logic [1:0] lv, logic [8:0] m, logic ret);
    int n;
    n = 0;
    while (vecReq.valid !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    guard(n);
    chk({11'h000, vecReq.source, vecReq.level, vecReq.addr},
        {11'h000, 3'(s), lv, 16'h0003 + 16'(s * 8)}, "vector");
    srcIn <= irq_src_t'(srcIn & ~m);
    n = 0;
    while (vecReq.valid === 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    guard(n);
    if (ret) begin
      idle(3);
      core.give_return();
    end
  endtask

  // ----
  // test sequence
  // ----
  initial begin
    logic [31:0] q;
    logic e;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(ADDR_LEVEL_HI, 32'h0000_0000, "hi reset");
    rd(ADDR_ENABLE, 32'h0000_0000, "en reset");
    wr(ADDR_LEVEL_HI, 32'h0000_007f);
    rd(ADDR_LEVEL_HI, 32'h0000_007f, "hi rw");
    apb(1'b0, 12'h020, 32'h0000_0000, q, e);
    chk({31'h0000_0000, e}, 32'h0000_0001, "slverr");
    chk(q, 32'h0000_0000, "unmapped");
    wr(ADDR_LEVEL_HI, 32'h0000_0000);
    $display("registers done");
    // global enable alone, then source enable alone, must not pass
    srcIn <= irq_src_t'(9'h001);
    wr(ADDR_ENABLE, 32'h0000_007e);
    wr(ADDR_CTRL, 32'h0000_0001);
    idle(4);
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_ENABLE, 32'h0000_007f);
    idle(4);
    wr(ADDR_CTRL, 32'h0000_0001);
    wait_vec(SRC_EXT0, 2'h0, 9'h001, 1'b1);
    $display("enables done");
    for (int b = 0; b < 9; b++) begin
      srcIn <= irq_src_t'(9'h001 << b);
      wait_vec(src_of(b), 2'h0, 9'h1ff, 1'b1);
    end
    $display("vectors done");
    // all at one level with a slow core: fixed order, one at a time
    ackDelay <= 4'h4;
    srcIn <= irq_src_t'(9'h1ff);
    for (int s = 0; s < 7; s++) begin
      wait_vec(s, 2'h0, mask_of(s), 1'b1);
    end
    ackDelay <= 4'h0;
    $display("ties done");
    for (int lv = 0; lv < 4; lv++) begin
      wr(ADDR_LEVEL_HI, 32'(lv / 2) << 6);
      wr(ADDR_LEVEL_LO, 32'(lv % 2) << 6);
      srcIn <= irq_src_t'(9'h100);
      wait_vec(SRC_CNT, 2'(lv), 9'h100, 1'b1);
    end
    srcIn <= irq_src_t'(9'h001);
    wait_vec(SRC_EXT0, 2'h0, 9'h001, 1'b0);
    srcIn <= irq_src_t'(9'h100);
    wait_vec(SRC_CNT, 2'h3, 9'h100, 1'b1);
    core.give_return();
    $display("levels done");
    rd(ADDR_IRQ_STAT, 32'h0000_0003, "ev stat");
    chk({31'h0000_0000, irqOut}, 32'h0000_0000, "irq masked");
    wr(ADDR_IRQ_EN, 32'h0000_0001);
    @(posedge clk_sys);
    chk({31'h0000_0000, irqOut}, 32'h0000_0001, "irq on");
    wr(ADDR_IRQ_CLR, 32'h0000_0001);
    @(posedge clk_sys);
    chk({31'h0000_0000, irqOut}, 32'h0000_0000, "irq clr");
    rd(ADDR_IRQ_STAT, 32'h0000_0002, "stat clr");
    srcIn <= irq_src_t'(9'h002);
    wait_vec(SRC_TMR0, 2'h0, 9'h002, 1'b1);
    chk({31'h0000_0000, irqOut}, 32'h0000_0001, "irq again");
    srcIn <= irq_src_t'(9'h004);
    wait_vec(SRC_EXT1, 2'h0, 9'h004, 1'b0);
    rd(ADDR_STATUS, 32'h0000_0100, "in service");
    wr(ADDR_CTRL, 32'h0000_0003);
    rd(ADDR_STATUS, 32'h0000_0000, "retired by write");
    $display("interrupt done");
    stop_test();
  end
endmodule
